//--- mrp_pkg.sv
// Shared constants and types for the mode register read path.
// Assumes one clock at 50 MHz for both ends; some values here are used by one end only and some by neither.
package mrp_pkg;

  localparam int unsigned CLK_PERIOD_PS = 20000;
  localparam int unsigned CLK_PER_MS    = 1000000000 / CLK_PERIOD_PS;

  localparam int unsigned CA_W  = 10;
  localparam int unsigned DQ_W  = 32;
  localparam int unsigned LANES = 4;
  localparam int unsigned MA_W  = 8;
  localparam int unsigned MR_W  = 8;
  localparam int unsigned BL_W  = 5;
  localparam int unsigned CNT_W = 8;

  // Latencies and burst figures in clock cycles
  localparam int unsigned READ_LAT_CYC         = 3;
  localparam int unsigned WRITE_LAT_CYC        = 1;
  localparam int unsigned MRR_BEATS            = 4;
  localparam int unsigned MODE_READ_PERIOD_CYC = 2;

  // Analog delays in picoseconds; the access and write-to-read delays are rounded up to whole cycles
  localparam int unsigned STROBE_ACCESS_DELAY_MAX_PS = 5500;
  localparam int unsigned STROBE_TO_DATA_SKEW_PS     = 340;
  localparam int unsigned WRITE_TO_READ_DELAY_PS     = 7500;
  localparam int unsigned DQSCK_CYC =
    (STROBE_ACCESS_DELAY_MAX_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WTR_CYC =
    (WRITE_TO_READ_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam int unsigned MRR_TO_MRW_CYC =
    READ_LAT_CYC + DQSCK_CYC + MRR_BEATS / 2 + 1;
  localparam int unsigned MRR_TO_WRITE_CYC = MRR_TO_MRW_CYC - WRITE_LAT_CYC;
  localparam int unsigned WRITE_TO_MRR_FIXED_CYC = WRITE_LAT_CYC + 1 + WTR_CYC;

  // Thermal figures
  localparam int unsigned TEMP_UPDATE_MS        = 32;
  localparam int unsigned TEMP_UPDATE_CYC       = TEMP_UPDATE_MS * CLK_PER_MS;
  localparam int unsigned THERMAL_POLL_MS       = 100;
  localparam int unsigned THERMAL_POLL_CYC      = THERMAL_POLL_MS * CLK_PER_MS;
  localparam int unsigned SYSTEM_REACTION_MS    = 1;
  localparam int unsigned TEMP_SLOPE_LIMIT_C_S  = 10;
  localparam int unsigned THERMAL_HEADROOM_C    = 2;

  // Register addresses and contents
  localparam logic [MA_W-1:0] THERMAL_STATUS_ADDR = 8'h04;
  localparam logic [MA_W-1:0] CAL_PATTERN_A_ADDR  = 8'h20;
  localparam logic [MA_W-1:0] CAL_PATTERN_B_ADDR  = 8'h28;
  localparam logic [3:0]      CAL_PATTERN_A       = 4'h5;
  localparam logic [3:0]      CAL_PATTERN_B       = 4'hC;
  localparam logic [MR_W-1:0] THERMAL_RST         = 8'h00;

  // Command codes on the rising-edge bits CA3..CA0
  localparam logic [3:0] CMD_MRR   = 4'h8;
  localparam logic [3:0] CMD_MRW   = 4'h0;
  localparam logic [3:0] CMD_WRITE = 4'h1;
  localparam logic [3:0] CMD_READ  = 4'h5;

  typedef enum logic [1:0] {
    MRP_REQ_MRR,
    MRP_REQ_MRW,
    MRP_REQ_READ,
    MRP_REQ_WRITE
  } mrp_req_e;

endpackage : mrp_pkg

//--- mrp_if.sv
// Command/address and data pins between controller and memory device.
// Assumes both ends share mclk; the data wire level is resolved here from the enable.
`timescale 1ns/100ps
interface mrp_if (
  input wire logic mclk_i
);
  logic                       cs_n;
  logic [mrp_pkg::CA_W-1:0]   ca_r;
  logic [mrp_pkg::CA_W-1:0]   ca_f;
  logic [mrp_pkg::DQ_W-1:0]   dq_out;
  logic                       dq_oe;
  logic [mrp_pkg::DQ_W-1:0]   dq;
  logic [mrp_pkg::LANES-1:0]  dqs_t;
  logic [mrp_pkg::LANES-1:0]  dqs_c;
  logic                       dqs_oe;

  // Undriven bus reads low in this model
  assign dq = dq_oe ? dq_out : '0;

  modport dev (
    input  cs_n, ca_r, ca_f,
    output dq_out, dq_oe, dqs_t, dqs_c, dqs_oe
  );
  modport ctl (
    output cs_n, ca_r, ca_f,
    input  dq, dq_oe, dqs_t, dqs_c, dqs_oe
  );
endinterface : mrp_if

//--- mrp_dev.sv
// Memory device end: decodes mode register reads and returns the burst.
// Assumes the controller keeps its own spacing; one data beat per clock in this model.
`timescale 1ns/100ps
module mrp_dev #(
  parameter int unsigned TEMP_UPDATE_CYCLES = mrp_pkg::TEMP_UPDATE_CYC
) (
  input  wire logic                      mclk_i,
  input  wire logic                      srst_i,
  mrp_if.dev                             bus,
  input  wire logic [2:0]                temp_sense_i,
  input  wire logic                      lp_exit_i,
  output logic      [mrp_pkg::MA_W-1:0]  mr_addr_o,
  input  wire logic [mrp_pkg::MR_W-1:0]  mr_data_i,
  output logic                           mrr_seen_o
);

  localparam int unsigned FIRST_POS = mrp_pkg::READ_LAT_CYC + 1;
  localparam int unsigned LAST_POS  = mrp_pkg::READ_LAT_CYC + mrp_pkg::MRR_BEATS;

  typedef enum logic [1:0] {
    MRP_SRC_USER,
    MRP_SRC_THERMAL,
    MRP_SRC_CAL_A,
    MRP_SRC_CAL_B
  } mrp_src_e;

  logic                       mrr_hit;
  logic [mrp_pkg::MA_W-1:0]   addr_cmd;
  logic [mrp_pkg::CNT_W-1:0]  pos_q;
  logic [mrp_pkg::CNT_W-1:0]  pos_d;
  logic                       in_burst_d;
  logic [1:0]                 beat_d;
  mrp_src_e                   src_q;
  logic [mrp_pkg::MR_W-1:0]   val_q;
  logic                       fetch_q;
  logic [mrp_pkg::MA_W-1:0]   mr_addr_q;
  logic                       mrr_seen_q;
  logic [mrp_pkg::DQ_W-1:0]   dq_q;
  logic [mrp_pkg::DQ_W-1:0]   dq_d;
  logic                       dq_oe_q;
  logic [mrp_pkg::LANES-1:0]  dqs_q;
  logic                       pat_bit;
  logic [2:0]                 temp_s1_q;
  logic [2:0]                 temp_s2_q;
  logic [2:0]                 temp_s3_q;
  logic [2:0]                 temp_stable_q;
  logic [31:0]                tsi_cnt_q;
  logic [mrp_pkg::MR_W-1:0]   thermal_q;

  // Decode on the rising-edge bits while selected
  assign mrr_hit  = !bus.cs_n && (bus.ca_r[3:0] == mrp_pkg::CMD_MRR);
  assign addr_cmd = {bus.ca_r[9:4], bus.ca_f[1:0]};

  // Operation position: 1 on the edge after the command, beats at FIRST..LAST
  always_comb begin
    pos_d = pos_q;
    if (pos_q != '0) begin
      pos_d = (pos_q == mrp_pkg::CNT_W'(LAST_POS)) ? '0 : pos_q + 1'b1;
    end else if (mrr_hit) begin
      pos_d = mrp_pkg::CNT_W'(1);
    end
  end

  // Commands arriving mid-operation are ignored; the controller must not send them
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pos_q <= '0;
    end else begin
      pos_q <= pos_d;
    end
  end

  assign in_burst_d = (pos_d >= mrp_pkg::CNT_W'(FIRST_POS));
  assign beat_d     = 2'(pos_d - mrp_pkg::CNT_W'(FIRST_POS));

  // Pick the source at the command; user registers are fetched one cycle later
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      src_q      <= MRP_SRC_USER;
      mr_addr_q  <= '0;
      fetch_q    <= 1'b0;
      mrr_seen_q <= 1'b0;
    end else begin
      fetch_q    <= 1'b0;
      mrr_seen_q <= 1'b0;
      if (pos_q == '0 && mrr_hit) begin
        mr_addr_q  <= addr_cmd;
        fetch_q    <= 1'b1;
        mrr_seen_q <= 1'b1;
        if (addr_cmd == mrp_pkg::THERMAL_STATUS_ADDR) begin
          src_q <= MRP_SRC_THERMAL;
        end else if (addr_cmd == mrp_pkg::CAL_PATTERN_A_ADDR) begin
          src_q <= MRP_SRC_CAL_A;
        end else if (addr_cmd == mrp_pkg::CAL_PATTERN_B_ADDR) begin
          src_q <= MRP_SRC_CAL_B;
        end else begin
          src_q <= MRP_SRC_USER;
        end
      end
    end
  end

  // Value is frozen before the first beat, so a thermal update cannot tear it
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      val_q <= '0;
    end else if (fetch_q) begin
      val_q <= (src_q == MRP_SRC_THERMAL) ? thermal_q : mr_data_i;
    end
  end

  always_comb begin
    case (src_q)
      MRP_SRC_CAL_A: pat_bit = mrp_pkg::CAL_PATTERN_A[beat_d];
      MRP_SRC_CAL_B: pat_bit = mrp_pkg::CAL_PATTERN_B[beat_d];
      default:       pat_bit = 1'b0;
    endcase
  end

  // Per-lane beat content
  genvar l;
  generate
    for (l = 0; l < mrp_pkg::LANES; l++) begin : g_lane
      always_comb begin
        if (!in_burst_d) begin
          dq_d[l*8 +: 8] = 8'h00;
        end else if (src_q == MRP_SRC_CAL_A || src_q == MRP_SRC_CAL_B) begin
          dq_d[l*8 +: 8] = {8{pat_bit}};
        end else if (l == 0 && beat_d == 2'h0) begin
          dq_d[l*8 +: 8] = val_q;
        end else begin
          dq_d[l*8 +: 8] = 8'h00;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      dq_q    <= '0;
      dq_oe_q <= 1'b0;
    end else begin
      dq_q    <= dq_d;
      dq_oe_q <= in_burst_d;
    end
  end

  // One edge of the strobe per beat on every lane
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      dqs_q <= '0;
    end else if (in_burst_d) begin
      dqs_q <= ~dqs_q;
    end else begin
      dqs_q <= '0;
    end
  end

  // Sensor code comes from outside the clock domain
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      temp_s1_q     <= '0;
      temp_s2_q     <= '0;
      temp_s3_q     <= '0;
      temp_stable_q <= '0;
    end else begin
      temp_s1_q <= temp_sense_i;
      temp_s2_q <= temp_s1_q;
      temp_s3_q <= temp_s2_q;
      if (temp_s2_q == temp_s3_q) begin
        temp_stable_q <= temp_s3_q;
      end
    end
  end

  // Periodic refresh, forced again when leaving a low-power state
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tsi_cnt_q <= '0;
      thermal_q <= mrp_pkg::THERMAL_RST;
    end else if (lp_exit_i || tsi_cnt_q >= 32'(TEMP_UPDATE_CYCLES - 1)) begin
      tsi_cnt_q <= '0;
      thermal_q <= {thermal_q[7:3], temp_stable_q};
    end else begin
      tsi_cnt_q <= tsi_cnt_q + 32'd1;
    end
  end

  assign bus.dq_out  = dq_q;
  assign bus.dq_oe   = dq_oe_q;
  assign bus.dqs_t   = dqs_q;
  assign bus.dqs_c   = ~dqs_q | {mrp_pkg::LANES{~dq_oe_q}};
  assign bus.dqs_oe  = dq_oe_q;
  assign mr_addr_o   = mr_addr_q;
  assign mrr_seen_o  = mrr_seen_q;

endmodule : mrp_dev

//--- mrp_ctl.sv
// Controller end: issues MRR, MRW, READ and WRITE with the required spacing,
// captures MRR bursts and polls the thermal register. Assumes the device
// returns data READ_LAT_CYC cycles after it samples the command.
`timescale 1ns/100ps
module mrp_ctl #(
  parameter int unsigned POLL_CYCLES = mrp_pkg::THERMAL_POLL_CYC
) (
  input  wire logic                      mclk_i,
  input  wire logic                      srst_i,
  mrp_if.ctl                             bus,
  input  wire logic                      req_valid_i,
  input  wire logic [1:0]                req_kind_i,
  input  wire logic [mrp_pkg::MA_W-1:0]  req_addr_i,
  input  wire logic [mrp_pkg::MR_W-1:0]  req_data_i,
  input  wire logic [mrp_pkg::BL_W-1:0]  req_bl_i,
  input  wire logic                      banks_idle_i,
  output logic                           req_ready_o,
  output logic                           req_err_o,
  output logic                           rd_valid_o,
  output logic      [mrp_pkg::MR_W-1:0]  rd_data_o,
  output logic      [3:0]                rd_pattern_o,
  output logic      [2:0]                temp_o
);

  localparam int unsigned CAP_FIRST = mrp_pkg::READ_LAT_CYC + 2;
  localparam int unsigned CAP_LAST  = CAP_FIRST + mrp_pkg::MRR_BEATS - 1;

  logic                        pend_q;
  mrp_pkg::mrp_req_e           kind_q;
  logic [mrp_pkg::MA_W-1:0]    addr_q;
  logic [mrp_pkg::MR_W-1:0]    data_q;
  logic [mrp_pkg::BL_W-1:0]    bl_q;
  logic                        poll_q;
  logic [31:0]                 poll_cnt_q;
  logic                        poll_due_q;
  logic                        accept;
  logic                        is_cal;
  logic                        gate_ok;
  logic                        issue;
  logic [mrp_pkg::CNT_W-1:0]   cap_q;
  logic [mrp_pkg::CNT_W-1:0]   gap_wr_q;
  logic [mrp_pkg::CNT_W-1:0]   gap_mrw_q;
  logic [mrp_pkg::CNT_W-1:0]   gap_mrr_q;
  logic                        cs_n_q;
  logic [mrp_pkg::CA_W-1:0]    ca_r_q;
  logic [mrp_pkg::CA_W-1:0]    ca_f_q;
  logic                        ready_q;
  logic                        err_q;
  logic                        rd_valid_q;
  logic [mrp_pkg::MR_W-1:0]    rd_data_q;
  logic [3:0]                  pat_q;
  logic                        cap_poll_q;
  logic [2:0]                  temp_q;
  logic [mrp_pkg::CNT_W-1:0]   beat_idx;

  assign accept  = req_valid_i && ready_q;
  assign is_cal  = (req_addr_i == mrp_pkg::CAL_PATTERN_A_ADDR) ||
                   (req_addr_i == mrp_pkg::CAL_PATTERN_B_ADDR);

  // A pending MRR owns the bus until its last beat is captured
  always_comb begin
    case (kind_q)
      mrp_pkg::MRP_REQ_MRR:   gate_ok = (gap_mrr_q == '0);
      mrp_pkg::MRP_REQ_MRW:   gate_ok = (gap_mrw_q == '0);
      mrp_pkg::MRP_REQ_WRITE: gate_ok = (gap_wr_q == '0);
      default:                gate_ok = 1'b1;
    endcase
  end
  assign issue = pend_q && gate_ok && (cap_q == '0);

  // Holding slot; a due poll takes it when no user request is offered
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pend_q  <= 1'b0;
      kind_q  <= mrp_pkg::MRP_REQ_MRR;
      addr_q  <= '0;
      data_q  <= '0;
      bl_q    <= '0;
      poll_q  <= 1'b0;
      ready_q <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      err_q <= 1'b0;
      if (issue) begin
        pend_q  <= 1'b0;
        ready_q <= 1'b1;
      end else if (accept) begin
        if (mrp_pkg::mrp_req_e'(req_kind_i) == mrp_pkg::MRP_REQ_MRR && is_cal &&
            !banks_idle_i) begin
          err_q <= 1'b1;
        end else begin
          pend_q  <= 1'b1;
          ready_q <= 1'b0;
          kind_q  <= mrp_pkg::mrp_req_e'(req_kind_i);
          addr_q  <= req_addr_i;
          data_q  <= req_data_i;
          bl_q    <= req_bl_i;
          poll_q  <= 1'b0;
        end
      end else if (!pend_q && poll_due_q) begin
        pend_q  <= 1'b1;
        ready_q <= 1'b0;
        kind_q  <= mrp_pkg::MRP_REQ_MRR;
        addr_q  <= mrp_pkg::THERMAL_STATUS_ADDR;
        poll_q  <= 1'b1;
      end else begin
        ready_q <= !pend_q;
      end
    end
  end

  // Poll timer; interval chosen so slope times total delay stays under headroom
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      poll_cnt_q <= '0;
      poll_due_q <= 1'b0;
    end else begin
      // Clear before set, so a due tick in the issue cycle is not lost
      if (issue && poll_q) begin
        poll_due_q <= 1'b0;
      end
      if (poll_cnt_q >= 32'(POLL_CYCLES - 1)) begin
        poll_cnt_q <= '0;
        poll_due_q <= 1'b1;
      end else begin
        poll_cnt_q <= poll_cnt_q + 32'd1;
      end
    end
  end

  // Command pins; deselect is the NOP between commands
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cs_n_q <= 1'b1;
      ca_r_q <= '0;
      ca_f_q <= '0;
    end else if (issue) begin
      cs_n_q <= 1'b0;
      ca_f_q <= '0;
      case (kind_q)
        mrp_pkg::MRP_REQ_MRR: begin
          ca_r_q <= {addr_q[7:2], mrp_pkg::CMD_MRR};
          ca_f_q <= {8'h00, addr_q[1:0]};
        end
        mrp_pkg::MRP_REQ_MRW: begin
          ca_r_q <= {addr_q[7:2], mrp_pkg::CMD_MRW};
          ca_f_q <= {data_q, addr_q[1:0]};
        end
        mrp_pkg::MRP_REQ_READ:  ca_r_q <= {6'h00, mrp_pkg::CMD_READ};
        default:                ca_r_q <= {6'h00, mrp_pkg::CMD_WRITE};
      endcase
    end else begin
      cs_n_q <= 1'b1;
    end
  end

  // Effective burst length is latched with the request, so a stopped burst still counts in full
  function automatic int unsigned req_bl_q_half(input logic [mrp_pkg::BL_W-1:0] bl);
    req_bl_q_half = (int'(bl) + 1) / 2;
  endfunction : req_bl_q_half

  // Spacing counters, loaded at issue and counted down to zero
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      gap_wr_q  <= '0;
      gap_mrw_q <= '0;
      gap_mrr_q <= '0;
    end else begin
      if (gap_wr_q != '0)  gap_wr_q  <= gap_wr_q - 1'b1;
      if (gap_mrw_q != '0) gap_mrw_q <= gap_mrw_q - 1'b1;
      if (gap_mrr_q != '0) gap_mrr_q <= gap_mrr_q - 1'b1;
      if (issue && kind_q == mrp_pkg::MRP_REQ_MRR) begin
        gap_wr_q  <= mrp_pkg::CNT_W'(mrp_pkg::MRR_TO_WRITE_CYC - 1);
        gap_mrw_q <= mrp_pkg::CNT_W'(mrp_pkg::MRR_TO_MRW_CYC - 1);
      end else if (issue && kind_q == mrp_pkg::MRP_REQ_READ) begin
        gap_mrr_q <= mrp_pkg::CNT_W'(req_bl_q_half(bl_q) - 1);
      end else if (issue && kind_q == mrp_pkg::MRP_REQ_WRITE) begin
        gap_mrr_q <= mrp_pkg::CNT_W'(mrp_pkg::WRITE_TO_MRR_FIXED_CYC +
                     req_bl_q_half(bl_q) - 1);
      end
    end
  end

  // Capture window counts from the issue edge
  assign beat_idx = cap_q - mrp_pkg::CNT_W'(CAP_FIRST);
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cap_q      <= '0;
      cap_poll_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q  <= '0;
      pat_q      <= '0;
      temp_q     <= '0;
    end else begin
      rd_valid_q <= 1'b0;
      if (issue && kind_q == mrp_pkg::MRP_REQ_MRR) begin
        cap_q      <= mrp_pkg::CNT_W'(1);
        cap_poll_q <= poll_q;
      end else if (cap_q == mrp_pkg::CNT_W'(CAP_LAST)) begin
        cap_q <= '0;
        pat_q[3] <= bus.dq[0];
        if (cap_poll_q) begin
          temp_q <= rd_data_q[2:0];
        end else begin
          rd_valid_q <= 1'b1;
        end
      end else if (cap_q != '0) begin
        cap_q <= cap_q + 1'b1;
      end
      if (cap_q >= mrp_pkg::CNT_W'(CAP_FIRST) && cap_q < mrp_pkg::CNT_W'(CAP_LAST)) begin
        pat_q[beat_idx[1:0]] <= bus.dq[0];
        if (beat_idx == '0) begin
          rd_data_q <= bus.dq[7:0];
        end
      end
    end
  end

  assign bus.cs_n     = cs_n_q;
  assign bus.ca_r     = ca_r_q;
  assign bus.ca_f     = ca_f_q;
  assign req_ready_o  = ready_q;
  assign req_err_o    = err_q;
  assign rd_valid_o   = rd_valid_q;
  assign rd_data_o    = rd_data_q;
  assign rd_pattern_o = pat_q;
  assign temp_o       = temp_q;

endmodule : mrp_ctl

//--- mrp_properties.sv
// Concurrent checks on the pins between controller and device ends.
// Assumes one clock and a synchronous active-high reset; instantiated beside mrp_if.
`timescale 1ns/100ps
module mrp_properties (
  input wire logic                       mclk_i,
  input wire logic                       srst_i,
  input wire logic                       cs_n,
  input wire logic [mrp_pkg::CA_W-1:0]   ca_r,
  input wire logic [mrp_pkg::CA_W-1:0]   ca_f,
  input wire logic [mrp_pkg::DQ_W-1:0]   dq,
  input wire logic                       dq_oe,
  input wire logic [mrp_pkg::LANES-1:0]  dqs_t,
  input wire logic [mrp_pkg::LANES-1:0]  dqs_c,
  input wire logic                       dqs_oe
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  localparam logic [3:0] PAT_A = mrp_pkg::CAL_PATTERN_A;
  localparam logic [3:0] PAT_B = mrp_pkg::CAL_PATTERN_B;

  logic       mrr;
  logic       mrw;
  logic       wr;
  logic       rd;
  logic       cal;
  logic [7:0] addr_q;
  logic [2:0] beat_q;

  assign mrr = !cs_n && ca_r[3:0] == mrp_pkg::CMD_MRR;
  assign mrw = !cs_n && ca_r[3:0] == mrp_pkg::CMD_MRW;
  assign wr  = !cs_n && ca_r[3:0] == mrp_pkg::CMD_WRITE;
  assign rd  = !cs_n && ca_r[3:0] == mrp_pkg::CMD_READ;
  assign cal = addr_q == mrp_pkg::CAL_PATTERN_A_ADDR || addr_q == mrp_pkg::CAL_PATTERN_B_ADDR;

  // Address of the burst in flight, so data beats can be judged against it
  always_ff @(posedge mclk_i) begin
    if (srst_i) addr_q <= 8'h00;
    else if (mrr) addr_q <= {ca_r[9:4], ca_f[1:0]};
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i || !dq_oe) beat_q <= 3'h0;
    else beat_q <= beat_q + 3'h1;
  end

  chk_burst_four: assert property (mrr |-> ##1 !dq_oe [*3] ##1 dq_oe [*4] ##1 !dq_oe)
    else $error("mrr burst not four beats at read latency");
  chk_strobe_toggle: assert property (dq_oe && $past(dq_oe) |-> dqs_t == ~$past(dqs_t))
    else $error("strobe did not toggle during burst");
  chk_strobe_pair: assert property (dq_oe |-> dqs_oe && dqs_c == ~dqs_t)
    else $error("strobe pair not driven complementary");
  chk_cal_pattern: assert property (dq_oe && cal |->
    dq[0] == ((addr_q == mrp_pkg::CAL_PATTERN_B_ADDR) ? PAT_B[beat_q[1:0]]
                                                       : PAT_A[beat_q[1:0]]))
    else $error("calibration pattern wrong");
  chk_cal_lanes: assert property (dq_oe && cal |-> dq == {mrp_pkg::DQ_W{dq[0]}})
    else $error("calibration bits differ from bit 0");
  chk_mrr_quiet: assert property (mrr |=> cs_n [*8])
    else $error("command during mrr operation");
  chk_mrr_mrw_gap: assert property (mrr |-> ##1 !mrw [*6])
    else $error("mrw too soon after mrr");
  chk_mrr_write_gap: assert property (mrr |-> ##1 !wr [*5])
    else $error("write too soon after mrr");
  chk_read_mrr_gap: assert property (rd |=> !mrr)
    else $error("mrr too soon after read");
  chk_write_mrr_gap: assert property (wr |-> ##1 !mrr [*4])
    else $error("mrr too soon after write");
endmodule : mrp_properties

//--- mode_register_read_path_bench.sv
// Bench joining controller and device ends through mrp_if, driving user sides.
// Assumes shortened thermal update and poll counts; 50 MHz clock.
`timescale 1ns/100ps
module mode_register_read_path_bench;
  logic       mclk_i = 1'b0;
  logic       srst_i = 1'b1;
  logic       req_valid_i = 1'b0;
  logic       banks_idle_i = 1'b1;
  logic       lp_exit_i = 1'b0;
  logic [1:0] req_kind_i = 2'h0;
  logic [7:0] req_addr_i = 8'h00;
  logic [7:0] req_data_i = 8'h00;
  logic [7:0] mr_data_i = 8'h00;
  logic [4:0] req_bl_i = 5'h00;
  logic [2:0] temp_sense_i = 3'h0;
  logic [7:0] mr_addr_o, rd_data_o;
  logic [3:0] rd_pattern_o;
  logic [2:0] temp_o;
  logic       req_ready_o, req_err_o, rd_valid_o, mrr_seen_o;
  int num_errors = 0, check_count = 0, cyc = 0, last_cyc = 0, prev_cyc = 0, err_cnt = 0;
  int seen_cnt = 0;

  initial forever #10 mclk_i = ~mclk_i;

  mrp_if bus (.mclk_i(mclk_i));
  mrp_dev #(.TEMP_UPDATE_CYCLES(50)) i_mrp_dev (.mclk_i(mclk_i), .srst_i(srst_i),
    .bus(bus.dev), .temp_sense_i(temp_sense_i), .lp_exit_i(lp_exit_i),
    .mr_addr_o(mr_addr_o), .mr_data_i(mr_data_i), .mrr_seen_o(mrr_seen_o));
  mrp_ctl #(.POLL_CYCLES(1000)) i_mrp_ctl (.mclk_i(mclk_i), .srst_i(srst_i),
    .bus(bus.ctl), .req_valid_i(req_valid_i), .req_kind_i(req_kind_i),
    .req_addr_i(req_addr_i), .req_data_i(req_data_i), .req_bl_i(req_bl_i),
    .banks_idle_i(banks_idle_i), .req_ready_o(req_ready_o), .req_err_o(req_err_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_pattern_o(rd_pattern_o),
    .temp_o(temp_o));
  mrp_properties i_mrp_properties (.mclk_i(mclk_i), .srst_i(srst_i), .cs_n(bus.cs_n),
    .ca_r(bus.ca_r), .ca_f(bus.ca_f), .dq(bus.dq), .dq_oe(bus.dq_oe),
    .dqs_t(bus.dqs_t), .dqs_c(bus.dqs_c), .dqs_oe(bus.dqs_oe));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  // Command issue times, refusal pulses and the run ceiling
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (!srst_i && bus.cs_n === 1'b0) begin
      prev_cyc <= last_cyc;
      last_cyc <= cyc;
    end
    if (req_err_o === 1'b1) err_cnt <= err_cnt + 1;
    if (mrr_seen_o === 1'b1) seen_cnt <= seen_cnt + 1;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Holds the request until the edge that takes it, then lets one edge pass
  task automatic req(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid_i <= 1'b1;
    req_kind_i  <= k;
    req_addr_i  <= a;
    req_data_i  <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 300);
    req_valid_i <= 1'b0;
    @(posedge mclk_i);
  endtask : req

  task automatic rd_mrr(input logic [7:0] a);
    int n;
    n = 0;
    req(2'h0, a, 8'h00);
    while (rd_valid_o !== 1'b1 && n < 40) begin
      @(posedge mclk_i);
      n++;
    end
  endtask : rd_mrr

  task automatic t_plain();
    int s;
    s = seen_cnt;
    mr_data_i <= 8'hA5;
    rd_mrr(8'hC3);
    check("rd_data", {24'h0, rd_data_o}, 32'hA5);
    check("mr_addr", {24'h0, mr_addr_o}, 32'hC3);
    mr_data_i <= 8'h5A;
    rd_mrr(8'h3C);
    check("rd_data", {24'h0, rd_data_o}, 32'h5A);
    check("mr_addr", {24'h0, mr_addr_o}, 32'h3C);
    check("mrr_seen", seen_cnt - s, 32'h2);
    $display("test plain done");
  endtask : t_plain

  task automatic t_cal();
    rd_mrr(8'h20);
    check("pattern_a", {28'h0, rd_pattern_o}, 32'h5);
    rd_mrr(8'h28);
    check("pattern_b", {28'h0, rd_pattern_o}, 32'hC);
    $display("test cal done");
  endtask : t_cal

  task automatic t_cal_busy();
    int e;
    int t;
    e = err_cnt;
    t = last_cyc;
    banks_idle_i <= 1'b0;
    req(2'h0, 8'h28, 8'h00);
    repeat (15) @(posedge mclk_i);
    check("err_count", err_cnt - e, 32'h1);
    check("no_issue", last_cyc, t);
    banks_idle_i <= 1'b1;
    $display("test cal busy done");
  endtask : t_cal_busy

  task automatic t_thermal();
    int n;
    n = 0;
    temp_sense_i <= 3'h3;
    repeat (5) @(posedge mclk_i);
    lp_exit_i <= 1'b1;
    @(posedge mclk_i);
    lp_exit_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rd_mrr(8'h04);
    check("thermal", {24'h0, rd_data_o}, 32'h03);
    temp_sense_i <= 3'h5;
    // Beyond one update interval plus the sensor synchroniser
    repeat (60) @(posedge mclk_i);
    rd_mrr(8'h04);
    check("thermal", {24'h0, rd_data_o}, 32'h05);
    while (temp_o !== 3'h5 && n < 1200) begin
      @(posedge mclk_i);
      n++;
    end
    check("temp_poll", {29'h0, temp_o}, 32'h5);
    $display("test thermal done");
  endtask : t_thermal

  task automatic t_gap(input logic [1:0] k1, input logic [7:0] d1, input logic [1:0] k2,
                       input logic [7:0] d2, input int min);
    int t0;
    t0 = last_cyc;
    req_bl_i <= d1[4:0];
    req(k1, 8'h11, d1);
    req_bl_i <= d2[4:0];
    req(k2, 8'h11, d2);
    // Long enough for the slowest second command to have reached the pins
    repeat (12) @(posedge mclk_i);
    check("gap", {31'h0, (last_cyc - prev_cyc) >= min}, 32'h1);
    check("gap_pair", {31'h0, prev_cyc > t0}, 32'h1);
    repeat (4) @(posedge mclk_i);
    $display("test gap done");
  endtask : t_gap

  initial begin
    repeat (12) @(posedge mclk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    t_plain();
    t_cal();
    t_cal_busy();
    t_thermal();
    t_gap(2'h3, 8'h08, 2'h0, 8'h00, 7);
    t_gap(2'h2, 8'h10, 2'h0, 8'h00, 8);
    t_gap(2'h0, 8'h00, 2'h1, 8'h55, 7);
    t_gap(2'h0, 8'h00, 2'h3, 8'h04, 6);
    complete_run();
  end
endmodule : mode_register_read_path_bench
